// file: rtl/acs_pkg.sv
// Package of constants and carrier types for the administrative command block.
package acs_pkg;

  // ==========================================================================
  // Register offsets and field positions
  localparam logic [11:0] ADMIN_COMMAND_OFF    = 12'h0A0;
  localparam logic [11:0] CMD_STATUS_OFF       = 12'h0A8;
  localparam logic [11:0] INT_REASON_OFF       = 12'h098;
  localparam logic [11:0] SW_ERROR_LOG_OFF     = 12'h0A4;
  localparam int          CMD_IRQ_BIT          = 31;
  localparam int          CMD_CODE_LSB         = 20;
  localparam int          STATUS_ACTIVE_BIT    = 31;
  localparam int          STATUS_RESULT_LSB    = 8;
  localparam int          REASON_CMD_DONE_BIT  = 1;
  localparam int          REASON_SW_ERR_BIT    = 0;
  localparam int          GROUP_LSB            = 16;

  // ==========================================================================
  // Command codes
  localparam logic [4:0] OP_ENABLE_DEV  = 5'h01;
  localparam logic [4:0] OP_DISABLE_DEV = 5'h02;
  localparam logic [4:0] OP_DRAIN_ALL   = 5'h03;
  localparam logic [4:0] OP_ABORT_ALL   = 5'h04;
  localparam logic [4:0] OP_RESET_DEV   = 5'h05;
  localparam logic [4:0] OP_ENABLE_WQ   = 5'h06;
  localparam logic [4:0] OP_DISABLE_WQ  = 5'h07;
  localparam logic [4:0] OP_DRAIN_WQ    = 5'h08;
  localparam logic [4:0] OP_ABORT_WQ    = 5'h09;
  localparam logic [4:0] OP_RESET_WQ    = 5'h0A;
  localparam logic [4:0] OP_DRAIN_PASID = 5'h0B;
  localparam logic [4:0] OP_ABORT_PASID = 5'h0C;
  localparam logic [4:0] OP_REQ_HANDLE  = 5'h0D;

  // ==========================================================================
  // Error codes and reset values
  localparam logic [7:0]  ERR_NONE      = 8'h00;
  localparam logic [7:0]  ERR_BAD_CODE  = 8'h01;
  localparam logic [7:0]  ERR_BAD_INDEX = 8'h02;
  localparam logic [7:0]  ERR_NOT_DIS   = 8'h10;
  localparam logic [7:0]  ERR_NOT_EN    = 8'h20;
  localparam logic [7:0]  ERR_WQ_NOT_DIS= 8'h21;
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
  localparam logic [1:0]  DEV_DISABLED  = 2'h0;
  localparam logic [1:0]  DEV_ENABLED   = 2'h1;
  localparam logic [1:0]  DEV_DRAINING  = 2'h2;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic        irq_req;
    logic [5:0]  rsvd;
    logic [4:0]  code;
    logic [19:0] operand;
  } acs_cmd_t;

  typedef struct packed {
    logic        active;
    logic [6:0]  unused;
    logic [15:0] result;
    logic [7:0]  error;
  } acs_status_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b11,
    ST_DONE = 2'b10
  } acs_state_t;

endpackage : acs_pkg

// file: rtl/acs_wq_mem.sv
// Small memory holding one enable bit per work queue, with registered read.
`timescale 1ns/1ps
module acs_wq_mem
  import acs_pkg::*;
#(
  parameter int NUM_WQ = 16
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              clr_all,
  input  wire logic              wr_en,
  input  wire logic [NUM_WQ-1:0] wr_mask,
  input  wire logic              wr_val,
  output logic      [NUM_WQ-1:0] rd_data
);

  logic [NUM_WQ-1:0] mem;
  logic [NUM_WQ-1:0] next_mem;

  // ==========================================================================
  // Per-queue next value; a device reset clears every entry at once.
  genvar i;
  generate
    for (i = 0; i < NUM_WQ; i++) begin : g_wq
      always_comb begin
        next_mem[i] = mem[i];
        if (clr_all) begin
          next_mem[i] = 1'b0;
        end else if (wr_en && wr_mask[i]) begin
          next_mem[i] = wr_val;
        end
      end
    end
  endgenerate

  // Storage and a registered read port.
  always_ff @(posedge clk) begin
    if (srst) begin
      mem     <= '0;
      rd_data <= '0;
    end else begin
      mem     <= next_mem;
      rd_data <= next_mem;
    end
  end

endmodule : acs_wq_mem

// file: rtl/acs_admin_cmd.sv
// Administrative command register, command status and completion interrupt.
`timescale 1ns/1ps
module acs_admin_cmd
  import acs_pkg::*;
#(
  parameter int NUM_WQ     = 16,
  parameter bit HANDLE_CAP = 1'b1
) (
  input  wire logic              CORE_CLK,
  input  wire logic              SRST,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  input  wire logic [11:0]       REG_ADDR,
  input  wire logic [31:0]       REG_WDATA,
  input  wire logic              WORK_IDLE,
  input  wire logic [NUM_WQ-1:0] WQ_IDLE,
  input  wire logic              PASID_IDLE,
  output logic      [31:0]       REG_RDATA,
  output logic                   MSIX0_IRQ,
  output logic      [1:0]        DEV_STATE,
  output logic      [NUM_WQ-1:0] WQ_ENABLED,
  output logic                   DEV_CFG_CLEAR,
  output logic      [NUM_WQ-1:0] WQ_CFG_CLEAR,
  output logic                   ABORT_REQ,
  output logic      [19:0]       PASID_SEL
);

  // ==========================================================================
  // State
  acs_state_t        state, next_state;
  acs_cmd_t          cmd, next_cmd;
  acs_status_t       status, next_status;
  logic [1:0]        dev_state, next_dev_state;
  logic [1:0]        reason, next_reason;
  logic [31:0]       sw_err, next_sw_err;
  logic [NUM_WQ-1:0] wq_mask, next_wq_mask;
  logic              wq_wr, wq_val, dev_clr;
  logic [NUM_WQ-1:0] wq_rd;
  logic              irq, next_irq;
  logic              abort_q, next_abort;
  logic [NUM_WQ-1:0] wq_clr, next_wq_clr;
  logic              cfg_clr, next_cfg_clr;
  logic [31:0]       rdata, next_rdata;
  logic              cmd_wr;
  logic              c1_wr;

  assign cmd_wr = REG_WR && (REG_ADDR == ADMIN_COMMAND_OFF);
  assign c1_wr  = REG_WR && (REG_ADDR == INT_REASON_OFF);

  // Queue enable store; only group 0 exists, so queue disable and reset reject any other group field.
  // The store takes the next mask, so an enable decided in the execute cycle
  // writes its own queue rather than the mask left over from the last command.
  acs_wq_mem #(.NUM_WQ(NUM_WQ)) u_wq (
    .clk     (CORE_CLK),
    .srst    (SRST),
    .clr_all (dev_clr),
    .wr_en   (wq_wr),
    .wr_mask (next_wq_mask),
    .wr_val  (wq_val),
    .rd_data (wq_rd)
  );

  // ==========================================================================
  // Command sequencer: accept, execute, wait for drain, complete.
  always_comb begin
    next_state     = state;
    next_cmd       = cmd;
    next_status    = status;
    next_dev_state = dev_state;
    next_wq_mask   = wq_mask;
    next_abort     = 1'b0;
    next_cfg_clr   = 1'b0;
    next_wq_clr    = '0;
    next_irq       = 1'b0;
    wq_wr          = 1'b0;
    wq_val         = 1'b0;
    dev_clr        = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (cmd_wr) begin
          next_cmd           = acs_cmd_t'(REG_WDATA);
          next_cmd.rsvd      = '0;
          next_status.active = 1'b1;
          next_state         = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_status.error  = ERR_NONE;
        next_status.result = '0;
        next_state         = ST_DONE;
        next_wq_mask       = cmd.operand[NUM_WQ-1:0];
        unique case (cmd.code)
          OP_ENABLE_DEV: begin
            if (dev_state != DEV_DISABLED) begin
              next_status.error = ERR_NOT_DIS;
            end else begin
              next_dev_state = DEV_ENABLED;
            end
          end
          OP_DISABLE_DEV, OP_RESET_DEV: begin
            next_dev_state = DEV_DRAINING;
            next_abort     = 1'b1;
            next_state     = ST_WAIT;
          end
          OP_DRAIN_ALL, OP_DRAIN_WQ, OP_DRAIN_PASID: begin
            next_state = ST_WAIT;
          end
          OP_ABORT_ALL, OP_ABORT_WQ, OP_ABORT_PASID: begin
            next_abort = 1'b1;
            next_state = ST_WAIT;
          end
          OP_ENABLE_WQ: begin
            next_wq_mask = '0;
            if (cmd.operand[7:0] >= 8'(NUM_WQ)) begin
              next_status.error = ERR_BAD_INDEX;
            end else if (dev_state != DEV_ENABLED) begin
              next_status.error = ERR_NOT_EN;
            end else if (wq_rd[cmd.operand[3:0]]) begin
              next_status.error = ERR_WQ_NOT_DIS;
            end else begin
              next_wq_mask[cmd.operand[3:0]] = 1'b1;
              wq_wr  = 1'b1;
              wq_val = 1'b1;
            end
          end
          OP_DISABLE_WQ, OP_RESET_WQ: begin
            if (cmd.operand[19:GROUP_LSB] != 4'h0) begin
              next_status.error = ERR_BAD_INDEX;
            end else begin
              next_abort = 1'b1;
              next_state = ST_WAIT;
            end
          end
          OP_REQ_HANDLE: begin
            if (!HANDLE_CAP) begin
              next_status.error = ERR_BAD_CODE;
            end else begin
              next_status.result = cmd.operand[15:0];
            end
          end
          default: begin
            next_status.error = ERR_BAD_CODE;
          end
        endcase
      end
      ST_WAIT: begin
        // Drain targets are idle; device-wide, per-queue or per-space.
        if ((cmd.code inside {OP_DRAIN_WQ, OP_ABORT_WQ, OP_DISABLE_WQ, OP_RESET_WQ})
            ? &(WQ_IDLE | ~wq_mask)
            : (cmd.code inside {OP_DRAIN_PASID, OP_ABORT_PASID}) ? PASID_IDLE
            : WORK_IDLE) begin
          next_state = ST_DONE;
          if (cmd.code == OP_DISABLE_WQ || cmd.code == OP_RESET_WQ) begin
            wq_wr = 1'b1;
          end
          if (cmd.code == OP_RESET_WQ) begin
            next_wq_clr = wq_mask;
          end
          if (cmd.code == OP_DISABLE_DEV || cmd.code == OP_RESET_DEV) begin
            next_dev_state = DEV_DISABLED;
            dev_clr        = 1'b1;
            next_cfg_clr   = (cmd.code == OP_RESET_DEV);
          end
        end
      end
      ST_DONE: begin
        next_status.active = 1'b0;
        next_irq           = cmd.irq_req;
        next_state         = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Sticky cause bits and error log; a new event wins over a same-cycle clear.
  always_comb begin
    next_reason = reason;
    next_sw_err = sw_err;
    if (c1_wr) begin
      next_reason = reason & ~REG_WDATA[1:0];
    end
    if (SW_ERROR_LOG_OFF == REG_ADDR && REG_WR) begin
      next_sw_err = sw_err & ~REG_WDATA;
    end
    if (cmd_wr && state != ST_IDLE) begin
      next_sw_err[0]                = 1'b1;
      next_reason[REASON_SW_ERR_BIT] = 1'b1;
    end
    if (state == ST_DONE && cmd.irq_req) begin
      next_reason[REASON_CMD_DONE_BIT] = 1'b1;
    end
  end

  // Read mux; the command register itself reads as zero.
  always_comb begin
    next_rdata = '0;
    if (REG_RD) begin
      unique case (REG_ADDR)
        CMD_STATUS_OFF:   next_rdata = status;
        INT_REASON_OFF:   next_rdata = {30'h0, reason};
        SW_ERROR_LOG_OFF: next_rdata = sw_err;
        default:          next_rdata = '0;
      endcase
    end
  end

  // ==========================================================================
  // Registers.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state     <= ST_IDLE;
      cmd       <= acs_cmd_t'(WORD_RESET);
      status    <= acs_status_t'(WORD_RESET);
      dev_state <= DEV_DISABLED;
      wq_mask   <= '0;
      reason    <= '0;
      sw_err    <= WORD_RESET;
      irq       <= 1'b0;
      abort_q   <= 1'b0;
      wq_clr    <= '0;
      cfg_clr   <= 1'b0;
      rdata     <= WORD_RESET;
    end else begin
      state     <= next_state;
      cmd       <= next_cmd;
      status    <= next_status;
      dev_state <= next_dev_state;
      wq_mask   <= next_wq_mask;
      reason    <= next_reason;
      sw_err    <= next_sw_err;
      irq       <= next_irq;
      abort_q   <= next_abort;
      wq_clr    <= next_wq_clr;
      cfg_clr   <= next_cfg_clr;
      rdata     <= next_rdata;
    end
  end

  assign REG_RDATA     = rdata;
  assign MSIX0_IRQ     = irq;
  assign DEV_STATE     = dev_state;
  assign WQ_ENABLED    = wq_rd;
  assign DEV_CFG_CLEAR = cfg_clr;
  assign WQ_CFG_CLEAR  = wq_clr;
  assign ABORT_REQ     = abort_q;
  assign PASID_SEL     = cmd.operand;

  // ==========================================================================
  // Assertions.
  sequence s_accept;
    state == ST_IDLE && cmd_wr;
  endsequence

  a_busy_on_accept: assert property (@(posedge CORE_CLK) disable iff (SRST)
    s_accept |=> status.active) else $error("busy not set after accept");

  a_busy_clears: assert property (@(posedge CORE_CLK) disable iff (SRST)
    state == ST_DONE |=> !status.active && state == ST_IDLE)
    else $error("busy not cleared at completion");

  a_busy_drop: assert property (@(posedge CORE_CLK) disable iff (SRST)
    cmd_wr && state != ST_IDLE |=> sw_err[0] && $stable(cmd))
    else $error("busy write not dropped or logged");

  a_irq_cause: assert property (@(posedge CORE_CLK) disable iff (SRST)
    $rose(MSIX0_IRQ) |-> reason[REASON_CMD_DONE_BIT] && cmd.irq_req)
    else $error("interrupt without cause or request");

  a_bad_code: assert property (@(posedge CORE_CLK) disable iff (SRST)
    state == ST_EXEC && cmd.code == 5'h00 ##2 1 |-> status.error == ERR_BAD_CODE)
    else $error("reserved code not flagged");

  a_enable_dev: assert property (@(posedge CORE_CLK) disable iff (SRST)
    state == ST_EXEC && cmd.code == OP_ENABLE_DEV && dev_state == DEV_DISABLED
    |=> dev_state == DEV_ENABLED) else $error("enable device failed");

  a_drain_wait: assert property (@(posedge CORE_CLK) disable iff (SRST)
    state == ST_WAIT && cmd.code == OP_DRAIN_ALL && !WORK_IDLE |=> state == ST_WAIT)
    else $error("drain completed with work pending");

  a_handle_result: assert property (@(posedge CORE_CLK) disable iff (SRST)
    state == ST_EXEC && cmd.code == OP_REQ_HANDLE && HANDLE_CAP
    |=> status.result == $past(cmd.operand[15:0])) else $error("handle not returned");

  a_wq_enable: assert property (@(posedge CORE_CLK) disable iff (SRST)
    state == ST_EXEC && cmd.code == OP_ENABLE_WQ && next_status.error == ERR_NONE
    |=> wq_rd[$past(cmd.operand[3:0])]) else $error("queue enable not stored");

endmodule : acs_admin_cmd

// file: dv/acs_host_model.sv
// Host software model that drives the register strobes of the command block.
`timescale 1ns/1ps
module acs_host_model
  import acs_pkg::*;
(
  input  wire logic        clk,
  output logic             wr,
  output logic             rd,
  output logic      [11:0] addr,
  output logic      [31:0] wdata,
  input  wire logic [31:0] rdata
);
  // ==========================================================================
  // Bus cycles
  // Strobes rise after one edge and fall after the edge that samples them.
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 12'h000;
    wdata = 32'h0000_0000;
  end

  // One write strobe per word; data is inverted once released so no stale word lingers.
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask : reg_wr

  // Read data is registered; it stands for one cycle and is taken at the edge ending it.
  task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : reg_rd

  // Software polls the busy flag before it may write again.
  task automatic wait_idle(output bit ok);
    logic [31:0] s;
    ok = 1'b0;
    for (int i = 0; i < 60; i++) begin
      reg_rd(CMD_STATUS_OFF, s);
      if (s[STATUS_ACTIVE_BIT] === 1'b0) begin
        ok = 1'b1;
        break;
      end
    end
  endtask : wait_idle
endmodule : acs_host_model

// file: dv/admin_command_submission_tb.sv
// Self-checking bench for the administrative command block.
`timescale 1ns/1ps
module admin_command_submission_tb
  import acs_pkg::*;
;
  logic        clk, srst, wr, rd, work_idle, pasid_idle, msix, devclr, abort;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, s;
  logic [15:0] wq_idle, wq_en, wq_clr, wqclr, m, hidx;
  logic [1:0]  dev_state;
  logic [19:0] pasid_sel, op;
  logic [4:0]  codes [3];
  logic        cur_irq;
  int          failures, tests_run, irq_n, abort_n, devclr_n, n0, n1, idx;
  bit          ok;

  // ==========================================================================
  // Clock, design and host
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  acs_admin_cmd #(.NUM_WQ(16), .HANDLE_CAP(1'b1)) dut_u (
    .CORE_CLK(clk), .SRST(srst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
    .REG_WDATA(wdata), .WORK_IDLE(work_idle), .WQ_IDLE(wq_idle),
    .PASID_IDLE(pasid_idle), .REG_RDATA(rdata), .MSIX0_IRQ(msix),
    .DEV_STATE(dev_state), .WQ_ENABLED(wq_en), .DEV_CFG_CLEAR(devclr),
    .WQ_CFG_CLEAR(wq_clr), .ABORT_REQ(abort), .PASID_SEL(pasid_sel));

  acs_host_model host_u (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata),
    .rdata(rdata));

  // Pulses last one cycle, so they are counted at every edge rather than polled.
  always @(posedge clk) begin
    irq_n <= irq_n + int'(msix);
    abort_n <= abort_n + int'(abort);
    devclr_n <= devclr_n + int'(devclr);
    wqclr <= wqclr | wq_clr;
  end

  // ==========================================================================
  // Checking and command tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      failures++;
    end
  endtask : check

  // Reserved bits carry random values; the design has to ignore them.
  task automatic issue(input logic [4:0] code, input logic [19:0] opnd);
    cur_irq = 1'($urandom);
    n0 = irq_n;
    host_u.reg_wr(ADMIN_COMMAND_OFF, {cur_irq, 6'($urandom), code, opnd});
    host_u.reg_rd(CMD_STATUS_OFF, s);
    check(32'(s[STATUS_ACTIVE_BIT]), 32'h1);
  endtask : issue

  task automatic finish(input logic [7:0] err);
    host_u.wait_idle(ok);
    check(32'(ok), 32'h1);
    host_u.reg_rd(CMD_STATUS_OFF, s);
    check(32'(s[7:0]), 32'(err));
    check(32'(irq_n - n0), 32'(cur_irq));
    host_u.reg_rd(INT_REASON_OFF, s);
    check(32'(s[REASON_CMD_DONE_BIT]), 32'(cur_irq));
    host_u.reg_wr(INT_REASON_OFF, 32'h0000_0002);
    host_u.reg_rd(INT_REASON_OFF, s);
    check(32'(s[REASON_CMD_DONE_BIT]), 32'h0);
  endtask : finish

  task automatic run_cmd(input logic [4:0] code, input logic [19:0] opnd,
                         input logic [7:0] err);
    issue(code, opnd);
    finish(err);
  endtask : run_cmd

  // Only codes 1 to 13 are defined while the handle capability is present.
  function automatic logic [7:0] code_err(input logic [4:0] code);
    return (code == 5'h00 || code > OP_REQ_HANDLE) ? ERR_BAD_CODE : ERR_NONE;
  endfunction : code_err

  task automatic end_sim;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // ==========================================================================
  // Watchdog, sized well above the longest expected run.
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    end_sim();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    srst = 1'b1;
    work_idle = 1'b1;
    wq_idle = '1;
    pasid_idle = 1'b1;
    wqclr = '0;
    void'($urandom(62414));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    host_u.reg_rd(CMD_STATUS_OFF, s);
    check(s, WORD_RESET);
    check(32'(dev_state), 32'(DEV_DISABLED));
    // A command word at an unmapped offset must not start anything.
    host_u.reg_wr(12'h0B0, {1'b1, 6'h00, OP_ENABLE_DEV, 20'h00000});
    host_u.reg_rd(CMD_STATUS_OFF, s);
    check(32'(s[STATUS_ACTIVE_BIT]), 32'h0);
    for (int c = 0; c < 32; c += 14) begin
      run_cmd(5'(c + (c == 28 ? 3 : 0)), 20'($urandom), code_err(5'(c + (c == 28 ? 3 : 0))));
    end
    run_cmd(OP_ENABLE_DEV, 20'($urandom), ERR_NONE);
    check(32'(dev_state), 32'(DEV_ENABLED));
    run_cmd(OP_ENABLE_DEV, 20'h00000, ERR_NOT_DIS);
    idx = $urandom % 16;
    run_cmd(OP_ENABLE_WQ, {12'($urandom), 8'(idx)}, ERR_NONE);
    check(32'(wq_en[idx]), 32'h1);
    m = 16'($urandom) | (16'h0001 << idx);
    // Waiting commands stay busy until their idle condition is seen.
    codes = '{OP_DRAIN_ALL, OP_DRAIN_WQ, OP_DRAIN_PASID};
    for (int k = 0; k < 3; k++) begin
      op = (k == 1) ? {4'h0, m} : 20'($urandom);
      work_idle <= (k != 0);
      wq_idle <= (k == 1) ? ~m : '1;
      pasid_idle <= (k != 2);
      issue(codes[k], op);
      if (k == 0) begin
        host_u.reg_wr(ADMIN_COMMAND_OFF, {1'b0, 6'h00, OP_DISABLE_DEV, 20'h00000});
      end
      repeat (20) @(posedge clk);
      host_u.reg_rd(CMD_STATUS_OFF, s);
      check(32'(s[STATUS_ACTIVE_BIT]), 32'h1);
      if (k == 2) check(32'(pasid_sel), 32'(op));
      work_idle <= 1'b1;
      wq_idle <= '1;
      pasid_idle <= 1'b1;
      finish(ERR_NONE);
    end
    host_u.reg_rd(SW_ERROR_LOG_OFF, s);
    check(32'(s[0]), 32'h1);
    check(32'(dev_state), 32'(DEV_ENABLED));
    host_u.reg_wr(SW_ERROR_LOG_OFF, 32'h0000_0001);
    host_u.reg_wr(INT_REASON_OFF, 32'h0000_0001);
    // Each abort flavour must raise the abort request.
    codes = '{OP_ABORT_ALL, OP_ABORT_WQ, OP_ABORT_PASID};
    for (int k = 0; k < 3; k++) begin
      n1 = abort_n;
      run_cmd(codes[k], (k == 1) ? {4'h0, m} : 20'($urandom), ERR_NONE);
      check(32'(abort_n > n1), 32'h1);
    end
    run_cmd(OP_DISABLE_WQ, {4'h1, m}, ERR_BAD_INDEX);
    check(32'(wq_en[idx]), 32'h1);
    run_cmd(OP_DISABLE_WQ, {4'h0, m}, ERR_NONE);
    check(32'(wq_en[idx]), 32'h0);
    wqclr = '0;
    run_cmd(OP_RESET_WQ, {4'h0, m}, ERR_NONE);
    check(32'(wqclr), 32'(m));
    hidx = 16'($urandom);
    run_cmd(OP_REQ_HANDLE, {3'($urandom), 1'($urandom), hidx}, ERR_NONE);
    host_u.reg_rd(CMD_STATUS_OFF, s);
    check(32'(s[23:8]), 32'(hidx));
    n1 = devclr_n;
    run_cmd(OP_DISABLE_DEV, 20'($urandom), ERR_NONE);
    check(32'(dev_state), 32'(DEV_DISABLED));
    check(32'(devclr_n - n1), 32'h0);
    n1 = devclr_n;
    run_cmd(OP_RESET_DEV, 20'($urandom), ERR_NONE);
    check(32'(devclr_n - n1), 32'h1);
    check(32'(dev_state), 32'(DEV_DISABLED));
    end_sim();
  end
endmodule : admin_command_submission_tb
